// >>> shared/stb_consts.svh
`ifndef STB_CONSTS_SVH
`define STB_CONSTS_SVH

// ----------------------------------------
// address map, relative to accelerator base
// ----------------------------------------
`define STB_REG_BASE 24'h006000
`define STB_REG_SPAN 24'h000100
`define STB_MEM_BASE 24'h008000
`define STB_MEM_SPAN 24'h008000

// ----------------------------------------
// register offsets inside the 256-byte window
// ----------------------------------------
`define STB_OFS_REVISION 8'h00
`define STB_OFS_SOFT_RESET 8'h04
`define STB_OFS_ENABLE_ALLOC 8'h08
`define STB_OFS_COUNTER_UPDATE 8'h0C
`define STB_OFS_TIMER_CONTROL 8'h10
`define STB_OFS_TIMER_LOAD 8'h14
`define STB_OFS_TIMER_VALUE 8'h18
`define STB_OFS_PACKET_ROUTING 8'h1C

// ----------------------------------------
// revision word fields and values
// ----------------------------------------
`define STB_REV_SCHEME 2'h1
`define STB_REV_MAJOR 3'h1
`define STB_REV_CUSTOM 2'h0
`define STB_REV_MINOR 6'h00
`define STB_REV_RTL 5'h00
// arbitrary neutral module identifier
`define STB_REV_MODULE_IDENT 12'h5A3

// ----------------------------------------
// enable / allocation fields
// ----------------------------------------
`define STB_EN_BIT 31
`define STB_ALLOC_MSB 13
`define STB_ALLOC_RESET 14'h0200
`define STB_COUNTER_BYTES 15'h4000
`define STB_WIDE_BYTES 4'h8

`endif

// >>> shared/stb_pkg.sv
package stb_pkg;
    typedef enum logic [1:0] {STB_IDLE, STB_ACK} stb_bus_state_t;
    typedef logic [13:0] stb_alloc_t;
endpackage : stb_pkg

// >>> logic/stb_alloc_split.sv
`timescale 1ns/1ns
`include "stb_consts.svh"

module stb_alloc_split
    import stb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire stb_alloc_t wide_counter_count,
    output logic [14:0] wide_bytes,
    output logic [13:0] narrow_count,
    output logic narrow_only
);
    logic [17:0] next_wide_bytes;

    // ----------------------------------------
    // wide / narrow split, registered
    // ----------------------------------------
    always_comb begin
        next_wide_bytes = {1'b0, wide_counter_count, 3'h0};
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wide_bytes <= 15'h1000;
            narrow_count <= 14'h0C00;
            narrow_only <= 1'b0;
        end else if (next_wide_bytes < 18'(`STB_COUNTER_BYTES)) begin
            // leftover space becomes 32-bit counters [RQ10]
            wide_bytes <= next_wide_bytes[14:0];
            narrow_count <= 14'((18'(`STB_COUNTER_BYTES) - next_wide_bytes) >> 2);
            narrow_only <= (wide_counter_count == 14'h0000); // [RQ11]
        end else begin
            // oversize allocation saturates to all wide
            wide_bytes <= `STB_COUNTER_BYTES;
            narrow_count <= 14'h0000;
            narrow_only <= 1'b0;
        end
    end

    AST_ZERO_ALL_NARROW: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wide_counter_count == 14'h0000 |=> narrow_only && narrow_count == 14'h1000) // [RQ11]
        else $error("zero allocation not narrow only");
    AST_SPLIT_SUM: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $past(wide_counter_count) < 14'h0800 && !$past(sys_rst)
        |-> 16'(wide_bytes) + 16'({narrow_count, 2'b00}) == 16'h4000) // [RQ10]
        else $error("split does not fill counter space");
endmodule : stb_alloc_split

// >>> logic/stb_regs.sv
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ns
`include "stb_consts.svh"

// Notes on behaviour
// (RQ1) register window 256 bytes at 006000h
// (RQ2) counter memory 32K window at 008000h
// (RQ3) offsets are relative to accelerator base
// (RQ4) eight registers at consecutive word offsets
// (RQ5) revision word read-only with fixed fields
// (RQ6) any soft-reset write clears engine state
// (RQ7) disabled engine: no counting, streams off
// (RQ8) allocation field bits 13-0, reset 200h
// (RQ9) software writes only even allocation
// (RQ10) leftover space used as 32-bit counters
// (RQ11) zero allocation means narrow counters only
// (RQ12) reserved bits zero, read-only writes ignored
// (RQ13) soft-reset reads zero, no side effect
module stb_regs
    import stb_pkg::*;
#(
    parameter int ADDR_W = 24
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    output logic mem_sel,
    output logic [14:0] mem_adr,
    output logic engine_enable,
    output logic stream_in_enable,
    output logic stream_out_enable,
    output logic count_enable,
    output logic soft_reset_pulse,
    output logic [13:0] wide_counter_count,
    output logic [14:0] wide_bytes,
    output logic [13:0] narrow_count,
    output logic narrow_only,
    output logic [31:0] counter_update,
    output logic [31:0] timer_control,
    output logic [31:0] timer_load,
    output logic [31:0] packet_routing,
    input wire logic [31:0] timer_value
);
    // decode works on a 24-bit offset: narrower cannot reach the memory window, wider is cut
    if (ADDR_W < 16 || ADDR_W > 24) begin : g_addr_w_check
        $error("ADDR_W outside 16 to 24");
    end

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    // decode is against the offset from the accelerator base, never absolute [RQ3]
    function automatic logic in_win(input logic [ADDR_W-1:0] a, input logic [23:0] base, input logic [23:0] span);
        in_win = (24'(a) >= base) && (24'(a) < base + span);
    endfunction : in_win

    logic req;
    logic reg_hit;
    logic mem_hit;
    logic [7:0] ofs;
    logic wr_go;
    logic [31:0] next_dat;
    logic next_err;
    stb_bus_state_t state;

    assign req = wb_cyc_i && wb_stb_i && state == STB_IDLE;
    assign reg_hit = in_win(wb_adr_i, `STB_REG_BASE, `STB_REG_SPAN); // [RQ1]
    assign mem_hit = in_win(wb_adr_i, `STB_MEM_BASE, `STB_MEM_SPAN); // [RQ2]
    assign ofs = 8'(24'(wb_adr_i) - `STB_REG_BASE);
    assign wr_go = req && wb_we_i && reg_hit;

    // ----------------------------------------
    // bus handshake: one wait state, ack for one cycle
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= STB_IDLE;
        end else if (state == STB_IDLE && wb_cyc_i && wb_stb_i) begin
            state <= STB_ACK;
        end else begin
            state <= STB_IDLE;
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : merge

    logic [31:0] ea_merged;
    assign ea_merged = merge({engine_enable, 17'h00000, wide_counter_count}, wb_dat_i, wb_sel_i);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            engine_enable <= 1'b0; // [RQ7]
            wide_counter_count <= `STB_ALLOC_RESET; // [RQ8]
        end else if (wr_go && ofs == `STB_OFS_ENABLE_ALLOC) begin
            // reserved 30-14 dropped; odd counts kept as written [RQ12] [RQ9]
            engine_enable <= ea_merged[`STB_EN_BIT];
            wide_counter_count <= ea_merged[`STB_ALLOC_MSB:0]; // [RQ8]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            counter_update <= 32'h00000000;
            timer_control <= 32'h00000000;
            timer_load <= 32'h00000000;
            packet_routing <= 32'h00000000;
        end else if (wr_go) begin
            if (ofs == `STB_OFS_COUNTER_UPDATE) begin
                counter_update <= merge(counter_update, wb_dat_i, wb_sel_i);
            end else if (ofs == `STB_OFS_TIMER_CONTROL) begin
                timer_control <= merge(timer_control, wb_dat_i, wb_sel_i);
            end else if (ofs == `STB_OFS_TIMER_LOAD) begin
                timer_load <= merge(timer_load, wb_dat_i, wb_sel_i);
            end else if (ofs == `STB_OFS_PACKET_ROUTING) begin // [RQ4]
                packet_routing <= merge(packet_routing, wb_dat_i, wb_sel_i);
            end
        end
    end

    // any value, any lanes: a write alone triggers the clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= wr_go && ofs == `STB_OFS_SOFT_RESET; // [RQ6]
        end
    end

    // gating of counting and both streams by the enable
    assign count_enable = engine_enable && !soft_reset_pulse; // [RQ7]
    assign stream_in_enable = engine_enable; // [RQ7]
    assign stream_out_enable = engine_enable; // [RQ7]

    // ----------------------------------------
    // read path
    // ----------------------------------------
    always_comb begin
        next_dat = 32'h00000000;
        next_err = 1'b0;
        if (!reg_hit && !mem_hit) begin
            next_err = 1'b1;
        end else if (mem_hit) begin
            next_dat = 32'h00000000;
        end else if (ofs == `STB_OFS_REVISION) begin
            // fixed word, reserved 29-28 read zero [RQ5] [RQ12]
            next_dat = {`STB_REV_SCHEME, 2'b00, `STB_REV_MODULE_IDENT, `STB_REV_RTL,
                        `STB_REV_MAJOR, `STB_REV_CUSTOM, `STB_REV_MINOR};
        end else if (ofs == `STB_OFS_SOFT_RESET) begin
            next_dat = 32'h00000000; // [RQ13]
        end else if (ofs == `STB_OFS_ENABLE_ALLOC) begin
            next_dat = {engine_enable, 17'h00000, wide_counter_count}; // [RQ12]
        end else if (ofs == `STB_OFS_COUNTER_UPDATE) begin
            next_dat = counter_update;
        end else if (ofs == `STB_OFS_TIMER_CONTROL) begin
            next_dat = timer_control;
        end else if (ofs == `STB_OFS_TIMER_LOAD) begin
            next_dat = timer_load;
        end else if (ofs == `STB_OFS_TIMER_VALUE) begin
            next_dat = timer_value;
        end else if (ofs == `STB_OFS_PACKET_ROUTING) begin
            next_dat = packet_routing;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wb_dat_o <= 32'h00000000;
            wb_err_o <= 1'b0;
            wb_ack_o <= 1'b0;
            mem_sel <= 1'b0;
            mem_adr <= 15'h0000;
        end else begin
            wb_dat_o <= req && !wb_we_i ? next_dat : 32'h00000000;
            wb_err_o <= req && next_err;
            wb_ack_o <= req && !next_err;
            mem_sel <= req && mem_hit; // [RQ2]
            mem_adr <= 15'(24'(wb_adr_i) - `STB_MEM_BASE);
        end
    end

    stb_alloc_split u_split (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .wide_counter_count(wide_counter_count),
        .wide_bytes(wide_bytes),
        .narrow_count(narrow_count),
        .narrow_only(narrow_only)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_SOFT_RESET_ANY_VALUE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_go && ofs == `STB_OFS_SOFT_RESET |=> soft_reset_pulse ##1 !soft_reset_pulse) // [RQ6]
        else $error("soft reset write gave no single pulse");
    AST_DISABLED_QUIET: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !engine_enable |-> !count_enable && !stream_in_enable && !stream_out_enable) // [RQ7]
        else $error("disabled engine still active");
    AST_ALLOC_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_go && ofs == `STB_OFS_ENABLE_ALLOC && wb_sel_i == 4'hF
        |=> wide_counter_count == $past(wb_dat_i[13:0]) && engine_enable == $past(wb_dat_i[31])) // [RQ8]
        else $error("allocation write not stored");
    AST_REV_READ: assert property (@(posedge ref_clk) disable iff (sys_rst)
        req && !wb_we_i && reg_hit && ofs == `STB_OFS_REVISION
        |=> wb_ack_o && wb_dat_o[31:30] == 2'h1 && wb_dat_o[29:28] == 2'h0 && wb_dat_o[10:8] == 3'h1) // [RQ5]
        else $error("revision word wrong");
    AST_SOFT_RESET_READ: assert property (@(posedge ref_clk) disable iff (sys_rst)
        req && !wb_we_i && reg_hit && ofs == `STB_OFS_SOFT_RESET
        |=> wb_ack_o && wb_dat_o == 32'h00000000 && !soft_reset_pulse) // [RQ13]
        else $error("soft reset read not zero or had effect");
    AST_RESERVED_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
        req && !wb_we_i && reg_hit && ofs == `STB_OFS_ENABLE_ALLOC
        |=> wb_dat_o[30:14] == 17'h00000) // [RQ12]
        else $error("reserved bits not zero");
    AST_WINDOW_ACK: assert property (@(posedge ref_clk) disable iff (sys_rst)
        req && 24'(wb_adr_i) >= 24'h006000 && 24'(wb_adr_i) < 24'h006100 |=> wb_ack_o && !wb_err_o) // [RQ1]
        else $error("register window not acknowledged");
    AST_UNMAPPED_ERR: assert property (@(posedge ref_clk) disable iff (sys_rst)
        req && !reg_hit && !mem_hit |=> wb_err_o && !wb_ack_o ##1 !wb_err_o) // [RQ3]
        else $error("unmapped access not refused");
    AST_MEM_SELECT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        req && 24'(wb_adr_i) >= 24'h008000 && 24'(wb_adr_i) < 24'h010000 |=> mem_sel && wb_ack_o) // [RQ2]
        else $error("counter memory not selected");
    AST_ROUTING_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_go && ofs == 8'h1C && wb_sel_i == 4'hF |=> packet_routing == $past(wb_dat_i)) // [RQ4]
        else $error("routing register not at 1Ch");

    COV_ENABLE: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(engine_enable));
    COV_SOFT_RESET: cover property (@(posedge ref_clk) disable iff (sys_rst) soft_reset_pulse);
    COV_NARROW_ONLY: cover property (@(posedge ref_clk) disable iff (sys_rst) narrow_only);
    COV_UNMAPPED: cover property (@(posedge ref_clk) disable iff (sys_rst) wb_err_o);
endmodule : stb_regs

// >>> sim/stats_block_control_regs_tb.sv
`timescale 1ns/1ns
`include "stb_consts.svh"

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end

module stats_block_control_regs_tb;
    logic ref_clk;
    logic sys_rst;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [23:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] timer_value;
    logic [31:0] wb_dat_o, counter_update, timer_control, timer_load, packet_routing;
    logic wb_ack_o, wb_err_o, mem_sel, engine_enable, stream_in_enable, stream_out_enable;
    logic count_enable, soft_reset_pulse, narrow_only;
    logic [14:0] mem_adr, wide_bytes, r_madr, exp_madr;
    logic [13:0] wide_counter_count, narrow_count;
    logic [31:0] r_dat, d, e, dv[4];
    logic [3:0] s;
    logic r_ack, r_err, r_pulse, r_msel, r_cen;
    logic [13:0] corner[6] = '{14'h0000, 14'h0002, 14'h0200, 14'h07FE, 14'h0800, 14'h3FFE};
    logic [7:0] rw_ofs[4] = '{`STB_OFS_COUNTER_UPDATE, `STB_OFS_TIMER_CONTROL, `STB_OFS_TIMER_LOAD,
                              `STB_OFS_PACKET_ROUTING};
    logic [23:0] bad_adr[4] = '{24'h001000, 24'h005FFC, 24'h006100, 24'h010000};
    int n_errors = 0;
    int n_checks = 0;

    stb_regs #(.ADDR_W(24)) i_dut (.ref_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .mem_sel, .mem_adr, .engine_enable,
        .stream_in_enable, .stream_out_enable, .count_enable, .soft_reset_pulse, .wide_counter_count,
        .wide_bytes, .narrow_count, .narrow_only, .counter_update, .timer_control, .timer_load,
        .packet_routing, .timer_value);

    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [23:0] ra(input logic [7:0] o);
        return `STB_REG_BASE + {16'h0000, o};
    endfunction : ra

    function automatic logic [14:0] exp_wide(input logic [13:0] a);
        // large allocations saturate: all 4000h counter bytes hold wide counters
        return (a >= 14'h0800) ? 15'h4000 : {a[11:0], 3'h0};
    endfunction : exp_wide

    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    // classic cycle; answer sampled pre-update at the edge where ack is seen
    task automatic bus(input logic we, input logic [23:0] adr, input logic [3:0] sel, input logic [31:0] dat);
        r_ack = 1'h0;
        r_err = 1'h0;
        @(posedge ref_clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        // no local limit: a missing answer is left to the watchdog
        while (!r_ack && !r_err) begin
            @(posedge ref_clk);
            r_ack = wb_ack_o === 1'h1;
            r_err = wb_err_o === 1'h1;
            r_dat = wb_dat_o;
            r_pulse = soft_reset_pulse;
            r_msel = mem_sel;
            r_madr = mem_adr;
            r_cen = count_enable;
        end
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
    endtask : bus

    task automatic set_alloc(input logic en, input logic [13:0] a);
        logic [31:0] x;
        logic [14:0] w;
        x = $urandom;
        x[31] = en;
        x[13:0] = a;
        w = exp_wide(a);
        bus(1'h1, ra(`STB_OFS_ENABLE_ALLOC), 4'hF, x);
        repeat (3) @(posedge ref_clk);
        `CHK({engine_enable, stream_in_enable, stream_out_enable, count_enable}, {4{en}})
        `CHK(wide_counter_count, a)
        `CHK(wide_bytes, w)
        `CHK(narrow_count, 14'((15'h4000 - w) >> 2))
        `CHK(narrow_only, a == 14'h0000)
        bus(1'h0, ra(`STB_OFS_ENABLE_ALLOC), 4'hF, 32'h0);
        `CHK(r_dat, {en, 17'h0, a})
    endtask : set_alloc

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(17339));
        {sys_rst, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
        {wb_adr_i, wb_sel_i, wb_dat_i, timer_value} = '0;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'h0;
        `CHK({engine_enable, stream_in_enable, stream_out_enable, narrow_only}, 4'h0)
        `CHK({wide_counter_count, wide_bytes, narrow_count}, {14'h0200, 15'h1000, 14'h0C00})
        bus(1'h0, ra(`STB_OFS_ENABLE_ALLOC), 4'hF, 32'h0);
        `CHK(r_dat, 32'h00000200)
        e = {`STB_REV_SCHEME, 2'h0, `STB_REV_MODULE_IDENT, `STB_REV_RTL, `STB_REV_MAJOR, `STB_REV_CUSTOM,
             `STB_REV_MINOR};
        for (int i = 0; i < 2; i++) begin
            bus(1'h0, ra(`STB_OFS_REVISION), 4'hF, 32'h0);
            `CHK(r_dat, e)
            bus(1'h1, ra(`STB_OFS_REVISION), 4'hF, $urandom);
        end
        for (int i = 0; i < 18; i++) begin
            set_alloc(1'($urandom), (i < 6) ? corner[i] : 14'($urandom) & 14'h3FFE);
        end
        // soft reset while counting, odd data and lanes
        set_alloc(1'h1, 14'h0002);
        bus(1'h1, ra(`STB_OFS_SOFT_RESET), 4'($urandom), $urandom);
        `CHK({r_ack, r_pulse, r_cen}, 3'h6)
        @(posedge ref_clk);
        `CHK(soft_reset_pulse, 1'h0)
        bus(1'h0, ra(`STB_OFS_SOFT_RESET), 4'hF, 32'h0);
        `CHK({r_dat, r_pulse}, 33'h0)
        for (int i = 0; i < 4; i++) begin
            dv[i] = $urandom;
            bus(1'h1, ra(rw_ofs[i]), 4'hF, dv[i]);
            bus(1'h0, ra(rw_ofs[i]), 4'hF, 32'h0);
            `CHK(r_dat, dv[i])
        end
        `CHK({counter_update, timer_control, timer_load, packet_routing}, {dv[0], dv[1], dv[2], dv[3]})
        s = 4'($urandom);
        d = $urandom;
        for (int b = 0; b < 4; b++) begin
            e[8*b +: 8] = s[b] ? d[8*b +: 8] : dv[0][8*b +: 8];
        end
        bus(1'h1, ra(`STB_OFS_COUNTER_UPDATE), s, d);
        bus(1'h0, ra(`STB_OFS_COUNTER_UPDATE), 4'hF, 32'h0);
        `CHK(r_dat, e)
        timer_value <= $urandom;
        bus(1'h1, ra(`STB_OFS_TIMER_VALUE), 4'hF, $urandom);
        bus(1'h0, ra(`STB_OFS_TIMER_VALUE), 4'hF, 32'h0);
        `CHK(r_dat, timer_value)
        // outside both windows the answer is an error, never an ack
        for (int i = 0; i < 4; i++) begin
            bus(1'($urandom), bad_adr[i], 4'hF, $urandom);
            `CHK({r_err, r_ack, r_msel}, 3'h4)
        end
        bus(1'h0, ra(8'h20), 4'hF, 32'h0);
        `CHK({r_ack, r_dat}, 33'h100000000)
        for (int i = 0; i < 3; i++) begin
            exp_madr = (i == 2) ? 15'h7FFC : 15'($urandom) & 15'h7FFC;
            bus(1'(i), `STB_MEM_BASE + {9'h000, exp_madr}, 4'hF, $urandom);
            `CHK({r_ack, r_msel, r_madr, r_dat}, {2'h3, exp_madr, 32'h0})
        end
        close_out();
    end

    // ----------------------------------------
    // watchdog, well beyond the expected run
    // ----------------------------------------
    initial begin
        #100000;
        n_errors++;
        $display("ERROR t=%0t watchdog expired", $time);
        close_out();
    end
endmodule : stats_block_control_regs_tb
